// *** shared/trao_consts.vh ***
/*
 Constants for the temperature result, offset and alert block.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef TRAO_CONSTS_VH
`define TRAO_CONSTS_VH

// Result layout select values
`define TRAO_FMT_LEGACY     1'b0
`define TRAO_FMT_PRECISION  1'b1

// Alert flag clearing modes
`define TRAO_ALERT_LATCHED  1'b0
`define TRAO_ALERT_FOLLOW   1'b1

// Reset values
`define TRAO_RESULT_RST     16'h0000
`define TRAO_OFFSET_RST     16'h0000
`define TRAO_ALERT_LO_RST   16'h8000
`define TRAO_ALERT_HI_RST   16'h7fff

// Legacy and precision layout limits, legacy scaling
`define TRAO_LEGACY_MAX     16'h07ff
`define TRAO_LEGACY_MIN     16'hf800
`define TRAO_PREC_MAX       16'h7fff
`define TRAO_PREC_MIN       16'h8000
`define TRAO_LEGACY_SHIFT   3

// Register select codes on the host write port
`define TRAO_SEL_OFFSET     2'h0
`define TRAO_SEL_ALERT_LO   2'h1
`define TRAO_SEL_ALERT_HI   2'h2

// Sequencer states
`define TRAO_ST_INIT        2'h0
`define TRAO_ST_IDLE        2'h1
`define TRAO_ST_CONV        2'h2

`endif

// *** core/trao_core.v ***
/*
 Temperature result logic: conversion triggering, offset correction,
 result formatting, alert thresholds and the shared alert pin.
 Assumes a converter that returns a 16-bit precision-layout sample with
 a one-cycle done pulse, and a bus front end that turns host commands
 and register accesses into the one-cycle strobes on this module.
*/
`timescale 1ns/10ps
`default_nettype none
`include "trao_consts.vh"

// Behaviour
// - Without auto conversion or supply powered continuous mode, a conversion starts only on the host command.
// - With auto conversion, a conversion starts after presence detect ends.
// - Supply powered continuous mode repeats conversions without host commands.
// - Each completed conversion loads result registers and updates status bits.
// - Format select bit picks the layout; legacy after reset.
// - Precision layout: 16-bit two's complement, 7.8125 m LSB, +-256 range.
// - Legacy layout: 12-bit sign extended to 16, 62.5 m LSB, +-128.
// - Result reads zero degrees until the first conversion completes.
// - Offset registers use the same layout as the result.
// - Programmed offset is added to each measurement before storing.
// - Host can save the written offset into nonvolatile configuration.
// - Separate low and high alert thresholds in result layout.
// - Each conversion compares the result against both thresholds.
// - Low flag when below low limit, high flag when above high.
// - Alert flags clear according to the alert mode setting.
// - Alert pin enabled and supply powered: drive alert status out.
// - At initialisation reload thresholds and offset from nonvolatile copies.
module trao_core #(
	parameter W = 16
) (
	// Clock and reset
	input  wire         clock,
	input  wire         rst,
	// Configuration bits
	input  wire         result_format_select,
	input  wire         auto_conv_en,
	input  wire         cont_conv_en,
	input  wire         supply_powered,
	input  wire         alert_mode,
	input  wire         alert_pin_en,
	// Bus events
	input  wire         convert_cmd,
	input  wire         presence_done,
	input  wire         status_rd,
	// Host register writes
	input  wire         reg_wr,
	input  wire [1:0]   reg_sel,
	input  wire [W-1:0] reg_wdata,
	input  wire         offset_save,
	// Nonvolatile copies
	input  wire [W-1:0] nv_offset,
	input  wire [W-1:0] nv_alert_lo,
	input  wire [W-1:0] nv_alert_hi,
	// Converter
	input  wire         adc_done,
	input  wire [W-1:0] adc_data,
	output reg          adc_start_q,
	// Results and status
	output reg  [7:0]   result_high_byte_q,
	output reg  [7:0]   result_low_byte_q,
	output reg          conv_done_flag_q,
	output reg          alert_lo_flag_q,
	output reg          alert_hi_flag_q,
	output reg          busy_q,
	// Threshold and offset readback
	output reg  [W-1:0] offset_q,
	output reg  [W-1:0] alert_lo_q,
	output reg  [W-1:0] alert_hi_q,
	// Nonvolatile save request
	output reg          nv_save_q,
	output reg  [W-1:0] nv_save_data_q,
	// Open-drain alert pin, pulled low while alert active
	output reg          shared_io_alert_pin_o_q,
	output reg          shared_io_alert_pin_oe_q
);

	reg  [1:0]   state_q;
	reg  [1:0]   state_d;
	reg          pend_q;
	wire         trig;
	wire         start_req;
	wire         start;
	wire [W+2:0] raw_x;
	wire [W+2:0] off_x;
	wire [W+2:0] off_s;
	wire [W+2:0] sum;
	wire [W+2:0] leg;
	reg  [W-1:0] res_d;
	wire         below;
	wire         above;
	reg          lo_d;
	reg          hi_d;
	reg          done_d;

	localparam [15:0] RES_RST = `TRAO_RESULT_RST;

	assign trig = auto_conv_en ? presence_done : convert_cmd;
	assign start_req = pend_q | (cont_conv_en & supply_powered);
	assign start = (state_q == `TRAO_ST_IDLE) & start_req;

	always @* begin
		state_d = state_q;
		case (state_q)
			`TRAO_ST_INIT: begin
				state_d = `TRAO_ST_IDLE;
			end
			`TRAO_ST_IDLE: begin
				if (start_req) begin
					state_d = `TRAO_ST_CONV;
				end
			end
			`TRAO_ST_CONV: begin
				if (adc_done) begin
					state_d = `TRAO_ST_IDLE;
				end
			end
			default: begin
				state_d = `TRAO_ST_IDLE;
			end
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			state_q     <= `TRAO_ST_INIT;
			pend_q      <= 1'b0;
			adc_start_q <= 1'b0;
			busy_q      <= 1'b0;
		end else begin
			state_q     <= state_d;
			adc_start_q <= start;
			busy_q      <= (state_d == `TRAO_ST_CONV);
			// A trigger arriving while a start is taken stays pending
			if (trig) begin
				pend_q <= 1'b1;
			end else if (start) begin
				pend_q <= 1'b0;
			end
		end
	end

	// Offset scaled into precision units per layout
	assign raw_x = {{3{adc_data[W-1]}}, adc_data};
	assign off_x = {{3{offset_q[W-1]}}, offset_q};
	assign off_s = (result_format_select == `TRAO_FMT_PRECISION) ?
		off_x : {off_x[W-1:0], 3'b000};
	assign sum = raw_x + off_s;
	assign leg = {{`TRAO_LEGACY_SHIFT{sum[W+2]}}, sum[W+2:`TRAO_LEGACY_SHIFT]};

	always @* begin
		if (result_format_select == `TRAO_FMT_PRECISION) begin
			if (sum[W+2:W-1] == 4'h0 || sum[W+2:W-1] == 4'hf) begin
				res_d = sum[W-1:0];
			end else if (sum[W+2]) begin
				res_d = `TRAO_PREC_MIN;
			end else begin
				res_d = `TRAO_PREC_MAX;
			end
		end else begin
			if (leg[W+2:11] == 8'h00 || leg[W+2:11] == 8'hff) begin
				res_d = leg[W-1:0];
			end else if (leg[W+2]) begin
				res_d = `TRAO_LEGACY_MIN;
			end else begin
				res_d = `TRAO_LEGACY_MAX;
			end
		end
	end

	// Signed threshold compare in result layout
	assign below = $signed(res_d) < $signed(alert_lo_q);
	assign above = $signed(res_d) > $signed(alert_hi_q);

	always @* begin
		lo_d   = alert_lo_flag_q;
		hi_d   = alert_hi_flag_q;
		done_d = conv_done_flag_q;
		// Latched flags clear on status read
		if (status_rd) begin
			done_d = 1'b0;
			if (alert_mode == `TRAO_ALERT_LATCHED) begin
				lo_d = 1'b0;
				hi_d = 1'b0;
			end
		end
		// Set from comparison, set wins over clear
		if (state_q == `TRAO_ST_CONV && adc_done) begin
			done_d = 1'b1;
			if (alert_mode == `TRAO_ALERT_FOLLOW) begin
				lo_d = below;
				hi_d = above;
			end else begin
				lo_d = lo_d | below;
				hi_d = hi_d | above;
			end
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			// Legacy by default; zero reads same in both
			result_high_byte_q       <= RES_RST[15:8];
			result_low_byte_q        <= RES_RST[7:0];
			conv_done_flag_q         <= 1'b0;
			alert_lo_flag_q          <= 1'b0;
			alert_hi_flag_q          <= 1'b0;
			shared_io_alert_pin_o_q  <= 1'b0;
			shared_io_alert_pin_oe_q <= 1'b0;
		end else begin
			// Result and status update on completion
			if (state_q == `TRAO_ST_CONV && adc_done) begin
				result_high_byte_q <= res_d[W-1:8];
				result_low_byte_q  <= res_d[7:0];
			end
			conv_done_flag_q        <= done_d;
			alert_lo_flag_q         <= lo_d;
			alert_hi_flag_q         <= hi_d;
			shared_io_alert_pin_o_q <= 1'b0;
			shared_io_alert_pin_oe_q <= alert_pin_en & supply_powered &
				(lo_d | hi_d);
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			offset_q       <= `TRAO_OFFSET_RST;
			alert_lo_q     <= `TRAO_ALERT_LO_RST;
			alert_hi_q     <= `TRAO_ALERT_HI_RST;
			nv_save_q      <= 1'b0;
			nv_save_data_q <= `TRAO_OFFSET_RST;
		end else if (state_q == `TRAO_ST_INIT) begin
			offset_q   <= nv_offset;
			alert_lo_q <= nv_alert_lo;
			alert_hi_q <= nv_alert_hi;
			nv_save_q  <= 1'b0;
		end else begin
			if (reg_wr) begin
				case (reg_sel)
					`TRAO_SEL_OFFSET: begin
						offset_q <= reg_wdata;
					end
					`TRAO_SEL_ALERT_LO: begin
						alert_lo_q <= reg_wdata;
					end
					`TRAO_SEL_ALERT_HI: begin
						alert_hi_q <= reg_wdata;
					end
					default: begin
						offset_q <= offset_q;
					end
				endcase
			end
			nv_save_q <= offset_save;
			if (offset_save) begin
				nv_save_data_q <= offset_q;
			end
		end
	end

endmodule
`default_nettype wire

// *** testbench/trao_core_asserts.sv ***
/*
 Port checker for trao_core, bound to every instance.
 Assumes results land one cycle after a taken adc_done.
*/
`timescale 1ns/10ps
`default_nettype none
module trao_core_asserts (
	// Clock, reset and inputs
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        result_format_select,
	input wire logic        alert_mode,
	input wire logic        status_rd,
	input wire logic        offset_save,
	input wire logic        adc_done,
	// Outputs
	input wire logic        adc_start_q,
	input wire logic [7:0]  result_high_byte_q,
	input wire logic [7:0]  result_low_byte_q,
	input wire logic        conv_done_flag_q,
	input wire logic        alert_lo_flag_q,
	input wire logic        alert_hi_flag_q,
	input wire logic        busy_q,
	input wire logic [15:0] offset_q,
	input wire logic [15:0] alert_lo_q,
	input wire logic [15:0] alert_hi_q,
	input wire logic        nv_save_q,
	input wire logic [15:0] nv_save_data_q
);
	wire logic [15:0] res = {result_high_byte_q, result_low_byte_q};
	wire logic        fin = adc_done && busy_q;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_start; adc_start_q |-> busy_q ##1 !adc_start_q; endproperty
	a_start: assert property (p_start) else $error("start pulse");
	property p_load; fin |=> !busy_q && conv_done_flag_q; endproperty
	a_load: assert property (p_load) else $error("result load");
	property p_hold; !fin |=> $stable(res); endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_leg; fin && !result_format_select |=> res[15:11] inside
		{5'h00, 5'h1f}; endproperty
	a_leg: assert property (p_leg) else $error("legacy sign");
	property p_lo; fin && alert_mode |=> alert_lo_flag_q ==
		($signed(res) < $signed(alert_lo_q)); endproperty
	a_lo: assert property (p_lo) else $error("low flag");
	property p_hi; fin && alert_mode |=> alert_hi_flag_q ==
		($signed(res) > $signed(alert_hi_q)); endproperty
	a_hi: assert property (p_hi) else $error("high flag");
	property p_clr; status_rd && !alert_mode && !fin |=> !alert_lo_flag_q
		&& !alert_hi_flag_q && !conv_done_flag_q; endproperty
	a_clr: assert property (p_clr) else $error("flag clear");
	property p_save; offset_save |=> nv_save_q &&
		nv_save_data_q == $past(offset_q); endproperty
	a_save: assert property (p_save) else $error("offset save");
endmodule
bind trao_core trao_core_asserts u_chk (.*);
`default_nettype wire

// *** testbench/trao_adc_model.sv ***
/*
 Converter model: answers each start after dly+1 cycles.
 Data is valid only with done, inverted otherwise.
*/
`timescale 1ns/10ps
`default_nettype none
module trao_adc_model (
	// Control
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [3:0]  dly,
	input  wire logic [15:0] sample,
	// Answer
	output var logic         done_q,
	output wire logic [15:0] data
);
	logic [4:0] cnt_q;
	assign data = done_q ? sample : ~sample;
	always @(posedge clock) begin
		done_q <= cnt_q == 5'h01;
		if (rst)
			cnt_q <= 5'h00;
		else if (start)
			cnt_q <= {1'b0, dly} + 5'h01;
		else if (cnt_q != 5'h00)
			cnt_q <= cnt_q - 5'h01;
	end
endmodule
`default_nettype wire

// *** testbench/test_temp_result_offset_alert.sv ***
/*
 Bench for trao_core: triggers conversions, predicts each result except those of continuous mode.
 Assumes the converter model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module test_temp_result_offset_alert;
	logic        clock = 0, rst = 1, result_format_select = 0;
	logic        auto_conv_en = 0, cont_conv_en = 0, supply_powered = 0;
	logic        alert_mode = 1, alert_pin_en = 0, convert_cmd = 0;
	logic        presence_done = 0, status_rd = 0, reg_wr = 0;
	logic        offset_save = 0, chk_on = 1, seen_q = 0;
	logic        adc_done, adc_start_q, conv_done_flag_q, busy_q, nv_save_q;
	logic        alert_lo_flag_q, alert_hi_flag_q;
	logic        shared_io_alert_pin_o_q, shared_io_alert_pin_oe_q;
	logic [1:0]  reg_sel = 2'h0;
	logic [3:0]  dly = 4'h0;
	logic [7:0]  result_high_byte_q, result_low_byte_q;
	logic [15:0] reg_wdata = 16'h0, raw = 16'h0, ofs = 16'h0010, adc_data;
	logic [15:0] offset_q, alert_lo_q, alert_hi_q, nv_save_data_q;
	logic [17:0] exp_q[$];
	logic [31:0] lfsr = 32'h41876164;
	int          error_cnt = 0, n_tests = 0, n = 0;

	trao_core u_dut (.*, .nv_offset(16'h0010), .nv_alert_lo(16'hff00),
		.nv_alert_hi(16'h0400));
	trao_adc_model u_adc (.clock, .rst, .start(adc_start_q), .dly,
		.sample(raw), .done_q(adc_done), .data(adc_data));

	initial forever #2 clock = ~clock;

	function automatic logic [31:0] step(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Expected {low flag, high flag, result}
	function automatic logic [17:0] predict(logic [15:0] r, logic f);
		logic signed [18:0] s;
		logic [15:0]        v;
		int                 lim;
		s = {{3{r[15]}}, r} + (f ? {{3{ofs[15]}}, ofs} : {ofs[15], ofs, 3'h0});
		if (!f)
			s = s >>> 3;
		lim = f ? 32767 : 2047;
		v = s > lim ? 16'(lim) : s < -lim - 1 ? 16'(-lim - 1) : s[15:0];
		return {$signed(v) < $signed(16'hff00), $signed(v) > 16'sh0400, v};
	endfunction

	task automatic chk(string nm, logic [17:0] seen, logic [17:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conv(logic [15:0] r, logic f, logic a);
		raw <= r;
		result_format_select <= f;
		auto_conv_en <= a;
		presence_done <= a;
		convert_cmd <= !a;
		exp_q.push_back(predict(r, f));
		@(posedge clock);
		presence_done <= 0;
		convert_cmd <= 0;
		repeat (3) @(posedge clock);
		while (busy_q) @(posedge clock);
		@(posedge clock);
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clock)
		seen_q <= adc_done && busy_q;
	always @(negedge clock) begin
		if (seen_q && chk_on)
			chk("result", {alert_lo_flag_q, alert_hi_flag_q,
				result_high_byte_q, result_low_byte_q},
				exp_q.size() ? exp_q.pop_front() : 18'hx);
	end

	initial begin
		repeat (6) @(posedge clock);
		rst <= 0;
		repeat (3) @(posedge clock);
		#1 chk("res", {2'h0, result_high_byte_q, result_low_byte_q}, 0);
		chk("off", {2'h0, offset_q}, 18'h10);
		chk("alo", {2'h0, alert_lo_q}, 18'hff00);
		chk("ahi", {2'h0, alert_hi_q}, 18'h0400);
		@(posedge clock);
		reg_wr <= 1;
		reg_wdata <= 16'hfff8;
		@(posedge clock);
		reg_wr <= 0;
		offset_save <= 1;
		ofs = 16'hfff8;
		@(posedge clock);
		offset_save <= 0;
		// Random samples, both layouts, both trigger kinds
		for (int i = 0; i < 12; i++) begin
			lfsr = step(lfsr);
			dly <= lfsr[20:17];
			conv(lfsr[15:0], lfsr[16], lfsr[21]);
		end
		conv(16'h7fff, 0, 0);
		conv(16'h8000, 0, 0);
		conv(16'h8000, 1, 0);
		chk_on <= 0;
		supply_powered <= 1;
		cont_conv_en <= 1;
		repeat (80) begin
			@(posedge clock);
			n += adc_start_q;
		end
		cont_conv_en <= 0;
		repeat (40) @(posedge clock);
		chk_on <= 1;
		chk("cont", n >= 3, 1);
		alert_mode <= 0;
		alert_pin_en <= 1;
		status_rd <= 1;
		@(posedge clock);
		status_rd <= 0;
		conv(16'h7fff, 1, 0);
		chk("pin", {shared_io_alert_pin_o_q, shared_io_alert_pin_oe_q}, 1);
		status_rd <= 1;
		@(posedge clock);
		status_rd <= 0;
		@(posedge clock);
		#1 chk("clr", {alert_lo_flag_q, alert_hi_flag_q}, 0);
		give_verdict;
	end

	initial begin
		repeat (4000) @(posedge clock);
		error_cnt++;
		give_verdict;
	end
endmodule
`default_nettype wire
